// ==== mmcf_top.v ====
// Mode, configuration and address filter logic with its receive FIFO
`timescale 1ns/1ps
`include "mmcf_defines.vh"

// ***********************************
// Receive byte FIFO
// ***********************************
module mmcf_fifo #(
	parameter WIDTH = 9,
	parameter DEPTH = 8,
	parameter AW = 3
) (
	input wire clk,
	input wire rst_n,
	input wire in_valid,
	output reg in_ready,
	input wire [WIDTH-1:0] in_data,
	output reg out_valid,
	input wire out_ready,
	output wire [WIDTH-1:0] out_data
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0] wr_ptr_r;
	reg [AW-1:0] rd_ptr_r;
	reg [AW:0] count_r;
	wire push;
	wire pop;
	wire [AW:0] count_nxt;

	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;
	assign count_nxt = count_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
	assign out_data = mem[rd_ptr_r];

	// Storage is not reset, only the pointers, count and flags need a known value
	always @(posedge clk) begin
		if (push) begin
			mem[wr_ptr_r] <= in_data;
		end
	end

	// Flags are registered so both sides see flop outputs
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_ptr_r <= {AW{1'b0}};
			rd_ptr_r <= {AW{1'b0}};
			count_r <= {(AW+1){1'b0}};
			in_ready <= 1'b0;
			out_valid <= 1'b0;
		end else begin
			if (push) begin
				wr_ptr_r <= wr_ptr_r + {{(AW-1){1'b0}}, 1'b1};
			end
			if (pop) begin
				rd_ptr_r <= rd_ptr_r + {{(AW-1){1'b0}}, 1'b1};
			end
			count_r <= count_nxt;
			in_ready <= (count_nxt != DEPTH[AW:0]);
			out_valid <= (count_nxt != {(AW+1){1'b0}});
		end
	end
endmodule

// ***********************************
// Top of the block
// ***********************************
module mmcf_top #(
	parameter [1:0] PART_IDENT = 2'h2, // Arbitrary identity value
	parameter FIFO_DEPTH = 8,
	parameter FIFO_AW = 3
) (
	input wire clk,
	input wire rst_n,
	input wire [3:0] reg_addr,
	input wire reg_wr,
	input wire reg_rd,
	input wire [7:0] reg_wdata,
	output reg [7:0] reg_rdata,
	output reg reg_rvalid,
	input wire tx_frame_start,
	input wire tx_collision,
	output reg tx_clash_any,
	output reg tx_clash_limit,
	output reg tx_retry,
	output reg tx_ignore_carrier,
	output reg loopback_en,
	input wire dma_want,
	input wire [15:0] dma_left,
	input wire dma_end_marker,
	input wire dma_clear,
	output reg dma_request,
	output reg dma_end_seen,
	input wire rx_valid,
	input wire [7:0] rx_byte,
	input wire rx_last,
	input wire rx_crc_err,
	input wire rx_align_err,
	input wire rx_collision,
	input wire rx_self,
	output wire rx_ready,
	output wire buf_valid,
	output wire [7:0] buf_byte,
	output wire buf_last,
	input wire buf_ready,
	input wire rx_pkt_pending,
	output reg rx_frame_keep,
	output reg rx_frame_drop,
	output reg rx_remote_frame,
	output reg link_active,
	output reg power_down,
	output reg word_mode_pin,
	output reg [1:0] tx_partition,
	output reg [1:0] sram_size,
	output reg [1:0] bank_select,
	output reg end_marker_polarity,
	output reg byte_lane_order
);
	reg [1:0] rst_sync_r;
	wire rst_i_n;
	reg [2:0] txm_r;
	reg [5:0] rxm_r;
	reg [7:0] cfg0_r;
	reg [4:0] cfg1_r;
	reg [4:0] clash_r;
	reg rx_empty_r;
	reg [7:0] node_r [0:5];
	reg [7:0] hash_r [0:7];
	reg [2:0] eop_sync_r;
	reg [10:0] len_r;
	reg [47:0] dst_r;
	reg [15:0] type_r;
	reg [7:0] rd_nxt;
	wire [47:0] node_w;
	wire [63:0] hash_w;
	wire rx_take;
	wire fifo_in_ready;
	wire [8:0] fifo_out;
	wire eop_level;
	wire [10:0] len_nxt;
	wire link_on;
	wire own_hit;
	wire bcast;
	wire mcast;
	wire mc24_hit;
	wire hash_hit;
	wire [5:0] hash_idx;
	reg addr_ok;
	wire err_any;
	wire is_short;
	wire err_ok;
	wire self_block;
	integer i;
	genvar g;

	// Decodes a banked address for the station or hash window
	function bank_hit;
		input [3:0] addr;
		input [1:0] bank;
		input [1:0] want;
		begin
			bank_hit = addr[3] & (bank == want);
		end
	endfunction

	// ***********************************
	// Reset release
	// ***********************************
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_sync_r <= 2'h0;
		end else begin
			rst_sync_r <= {rst_sync_r[0], 1'b1};
		end
	end
	assign rst_i_n = rst_sync_r[1];

	// Flatten station and hash storage for the filter
	generate
		for (g = 0; g < 6; g = g + 1) begin : g_node
			assign node_w[8*g +: 8] = node_r[g];
		end
		for (g = 0; g < 8; g = g + 1) begin : g_hash
			assign hash_w[8*g +: 8] = hash_r[g];
		end
	endgenerate

	// ***********************************
	// Register writes
	// ***********************************
	always @(posedge clk or negedge rst_i_n) begin
		if (!rst_i_n) begin
			txm_r <= `MMCF_TXM_RST;
			rxm_r <= `MMCF_RXM_RST;
			cfg0_r <= {`MMCF_CFG0_HI_RST, `MMCF_CFG0_LO_RST};
			cfg1_r <= `MMCF_CFG1_RST;
			for (i = 0; i < 6; i = i + 1) begin
				node_r[i] <= 8'h00;
			end
			for (i = 0; i < 8; i = i + 1) begin
				hash_r[i] <= 8'h00;
			end
		end else if (reg_wr) begin
			case (reg_addr)
				`MMCF_OFS_TX_MODE: begin
					txm_r <= reg_wdata[2:0];
				end
				`MMCF_OFS_RX_MODE: begin
					rxm_r <= reg_wdata[5:0];
				end
				`MMCF_OFS_CFG0: begin
					cfg0_r <= reg_wdata;
				end
				`MMCF_OFS_CFG1: begin
					// Power bit is plain storage, so sleep keeps all state
					cfg1_r <= {reg_wdata[5], reg_wdata[3:0]};
				end
				default: begin
					if (bank_hit(reg_addr, cfg1_r[3:2], `MMCF_BANK_LINK) &&
						reg_addr <= `MMCF_OFS_STA_LAST) begin
						node_r[reg_addr[2:0]] <= reg_wdata;
					end
					if (bank_hit(reg_addr, cfg1_r[3:2], `MMCF_BANK_HASH)) begin
						hash_r[reg_addr[2:0]] <= reg_wdata;
					end
				end
			endcase
		end
	end

	// ***********************************
	// Register reads
	// ***********************************
	always @* begin
		rd_nxt = 8'h00;
		case (reg_addr)
			`MMCF_OFS_TX_MODE: begin
				rd_nxt = {clash_r[3:0], 1'b0, txm_r};
			end
			`MMCF_OFS_RX_MODE: begin
				rd_nxt = {1'b0, rx_empty_r, rxm_r};
			end
			`MMCF_OFS_CFG0: begin
				rd_nxt = cfg0_r;
			end
			`MMCF_OFS_CFG1: begin
				rd_nxt = {PART_IDENT, cfg1_r[4], 1'b0, cfg1_r[3:0]};
			end
			default: begin
				// Buffer port bank and reserved bank read zero here
				if (bank_hit(reg_addr, cfg1_r[3:2], `MMCF_BANK_LINK) &&
					reg_addr <= `MMCF_OFS_STA_LAST) begin
					rd_nxt = node_r[reg_addr[2:0]];
				end else if (bank_hit(reg_addr, cfg1_r[3:2],
					`MMCF_BANK_HASH)) begin
					rd_nxt = hash_r[reg_addr[2:0]];
				end
			end
		endcase
	end

	// Read data answers one cycle after the strobe
	always @(posedge clk or negedge rst_i_n) begin
		if (!rst_i_n) begin
			reg_rdata <= 8'h00;
			reg_rvalid <= 1'b0;
		end else begin
			reg_rvalid <= reg_rd;
			if (reg_rd) begin
				reg_rdata <= rd_nxt;
			end
		end
	end

	// ***********************************
	// Collision counter and retry
	// ***********************************
	always @(posedge clk or negedge rst_i_n) begin
		if (!rst_i_n) begin
			clash_r <= 5'h00;
			tx_retry <= 1'b0;
		end else begin
			tx_retry <= 1'b0;
			if (tx_frame_start) begin
				clash_r <= 5'h00;
			end else if (tx_collision && clash_r != `MMCF_COL_LIMIT) begin
				clash_r <= clash_r + 5'h01;
				// Last of sixteen attempts asks for no further retry
				tx_retry <= (clash_r != `MMCF_COL_LIMIT - 5'h01);
			end
		end
	end

	// ***********************************
	// Mode and configuration outputs
	// ***********************************
	always @(posedge clk or negedge rst_i_n) begin
		if (!rst_i_n) begin
			tx_clash_any <= 1'b0;
			tx_clash_limit <= 1'b0;
			tx_ignore_carrier <= 1'b0;
			loopback_en <= 1'b0;
			rx_empty_r <= 1'b1;
			link_active <= 1'b0;
			power_down <= 1'b0;
			word_mode_pin <= 1'b0;
			tx_partition <= 2'h0;
			sram_size <= 2'h0;
			bank_select <= 2'h0;
			end_marker_polarity <= 1'b0;
			byte_lane_order <= 1'b0;
		end else begin
			tx_clash_any <= (clash_r != 5'h00);
			tx_clash_limit <= (clash_r == `MMCF_COL_LIMIT);
			tx_ignore_carrier <= txm_r[0];
			loopback_en <= ~txm_r[1];
			rx_empty_r <= ~rx_pkt_pending;
			link_active <= ~cfg0_r[7];
			power_down <= ~cfg1_r[4];
			word_mode_pin <= ~cfg0_r[5];
			tx_partition <= cfg0_r[3:2];
			// Invalid size codes are passed on; software must avoid them
			sram_size <= cfg0_r[1:0];
			bank_select <= cfg1_r[3:2];
			end_marker_polarity <= cfg1_r[1];
			byte_lane_order <= cfg1_r[0];
		end
	end

	// ***********************************
	// DMA request and end marker
	// ***********************************
	always @(posedge clk or negedge rst_i_n) begin
		if (!rst_i_n) begin
			// Idle level of the reset polarity, so no false end follows reset
			eop_sync_r <= `MMCF_EOP_SYNC_RST;
		end else begin
			eop_sync_r <= {eop_sync_r[1:0], dma_end_marker};
		end
	end
	// Only the two settled stages are looked at
	assign eop_level = (eop_sync_r[2] == eop_sync_r[1]) & eop_sync_r[2];

	// End marker latches and inhibits the request until cleared
	always @(posedge clk or negedge rst_i_n) begin
		if (!rst_i_n) begin
			dma_end_seen <= 1'b0;
			dma_request <= 1'b0;
		end else begin
			if ((eop_sync_r[2] == eop_sync_r[1]) &&
				(eop_level == cfg1_r[1])) begin
				dma_end_seen <= 1'b1;
			end else if (dma_clear) begin
				dma_end_seen <= 1'b0;
			end
			dma_request <= dma_want & ~dma_end_seen & ~power_down &
				((dma_left > 16'h0001) ||
				(dma_left == 16'h0001 && !txm_r[2]));
		end
	end

	// ***********************************
	// Receive path and frame verdict
	// ***********************************
	assign rx_take = rx_valid & fifo_in_ready;
	assign rx_ready = fifo_in_ready;
	assign buf_byte = fifo_out[7:0];
	assign buf_last = fifo_out[8];
	assign len_nxt = (len_r == 11'h7FF) ? len_r : len_r + 11'h001;
	assign link_on = ~cfg0_r[7] & cfg1_r[4];

	mmcf_fifo #(
		.WIDTH(9),
		.DEPTH(FIFO_DEPTH),
		.AW(FIFO_AW)
	) u_fifo (
		.clk(clk),
		.rst_n(rst_i_n),
		.in_valid(rx_valid),
		.in_ready(fifo_in_ready),
		.in_data({rx_last, rx_byte}),
		.out_valid(buf_valid),
		.out_ready(buf_ready),
		.out_data(fifo_out)
	);

	// Destination arrives least significant bit first per byte
	assign bcast = &dst_r;
	assign mcast = dst_r[0];
	assign own_hit = ~dst_r[0] & (dst_r[47:1] == node_w[47:1]);
	assign mc24_hit = dst_r[0] & (dst_r[23:1] == node_w[23:1]);
	// Hash index is a fold of the destination bytes, cheap but not a CRC
	assign hash_idx = dst_r[5:0] ^ dst_r[13:8] ^ dst_r[21:16] ^
		dst_r[29:24] ^ dst_r[37:32] ^ dst_r[45:40];
	assign hash_hit = mcast & hash_w[hash_idx];
	assign self_block = rx_self & (bcast | mcast) &
		(rxm_r[1:0] != `MMCF_AF_ALL) & txm_r[1];

	always @* begin
		case (rxm_r[1:0])
			`MMCF_AF_REJECT: begin
				addr_ok = 1'b0;
			end
			`MMCF_AF_MCAST24: begin
				addr_ok = own_hit | bcast | mc24_hit;
			end
			`MMCF_AF_HASH: begin
				addr_ok = own_hit | bcast | hash_hit;
			end
			default: begin
				addr_ok = 1'b1;
			end
		endcase
	end

	// Length includes the last byte being taken now
	assign is_short = (len_nxt < `MMCF_MIN_FRAME);
	assign err_any = rx_crc_err | rx_align_err | is_short;
	assign err_ok = ~err_any | (~rx_collision & (rxm_r[5] |
		(rxm_r[3] & ~rx_crc_err & ~rx_align_err &
		len_nxt >= `MMCF_MIN_RUNT)));

	always @(posedge clk or negedge rst_i_n) begin
		if (!rst_i_n) begin
			len_r <= 11'h000;
			dst_r <= 48'h0;
			type_r <= 16'h0000;
			rx_frame_keep <= 1'b0;
			rx_frame_drop <= 1'b0;
			rx_remote_frame <= 1'b0;
		end else begin
			rx_frame_keep <= 1'b0;
			rx_frame_drop <= 1'b0;
			rx_remote_frame <= 1'b0;
			if (rx_take) begin
				len_r <= rx_last ? 11'h000 : len_nxt;
				if (len_r < 11'h006) begin
					dst_r[8*len_r[2:0] +: 8] <= rx_byte;
				end
				if (len_r == 11'h00C) begin
					type_r[15:8] <= rx_byte;
				end
				if (len_r == 11'h00D) begin
					type_r[7:0] <= rx_byte;
				end
				if (rx_last) begin
					// Frames shorter than an address never match
					if (link_on && addr_ok && err_ok && !self_block &&
						len_nxt >= `MMCF_MIN_RUNT) begin
						rx_frame_keep <= 1'b1;
						rx_remote_frame <= rxm_r[2] &
							(type_r == `MMCF_REMOTE_TYPE);
					end else begin
						rx_frame_drop <= 1'b1;
					end
				end
			end
		end
	end
endmodule

// ==== mmcf_defines.vh ====
// Constants for the mode, configuration and address filter block
//
// What this block does
// - Transmit mode bits 7:4 read back the consecutive collision count.
// - Counts 1-15 show in binary; count 16 reads zero with sixteen flag.
// - Hold low: DMA request lasts through final cycle, else drops earlier.
// - Loopback control bit zero routes encoder output into decoder.
// - Defer disable set lets the transmitter ignore network carrier.
// - Read-only buffer empty bit, set after reset, high when nothing ready.
// - Accept-bad keeps CRC, alignment, short errored frames without collision.
// - Accept-short keeps clean frames from 6 to 59 bytes; else dropped.
// - Remote control enable lets type 0900 frames be recognised and reported.
// - Filter 00 none, 01 own/broadcast/multicast matching first 24 bits, 10 hash, 11 everything.
// - Station match: first bit zero, remaining 47 bits equal stored address.
// - Transmit partition: 1x2K, 2x2K, 2x4K or 2x8K by code 00..11.
// - Bus width bit high means 8-bit bus; word mode pin is its inverse.
// - Link enable low runs the link; station set up only while high, but station writes are accepted in either state.
// - Power bit zero sleeps, one wakes, contents kept, reset also wakes.
// - Top two bits of configuration one read a fixed part identity.
// - Bank select maps addresses 08-0F to link, hash or buffer port banks.
// - End marker pin active high when polarity bit set, else active low.
// - Byte order bit picks the lane of odd packet bytes in word mode.
// - Six station address registers at bank 08-0D, first is first received.
// - Each collision requests a retransmit, at most sixteen attempts.
`ifndef MMCF_DEFINES_VH
`define MMCF_DEFINES_VH

// ***********************************
// Register offsets
// ***********************************
`define MMCF_OFS_TX_MODE 4'h4
`define MMCF_OFS_RX_MODE 4'h5
`define MMCF_OFS_CFG0 4'h6
`define MMCF_OFS_CFG1 4'h7
`define MMCF_OFS_STA_FIRST 4'h8
`define MMCF_OFS_STA_LAST 4'hD

// ***********************************
// Bank codes
// ***********************************
`define MMCF_BANK_LINK 2'h0
`define MMCF_BANK_HASH 2'h1

// ***********************************
// Filter modes
// ***********************************
`define MMCF_AF_REJECT 2'h0
`define MMCF_AF_MCAST24 2'h1
`define MMCF_AF_HASH 2'h2
`define MMCF_AF_ALL 2'h3

// ***********************************
// Reset values of the writable fields and the end marker synchronizer
// ***********************************
`define MMCF_TXM_RST 3'h6
`define MMCF_RXM_RST 6'h02
`define MMCF_CFG0_HI_RST 4'hB
`define MMCF_CFG0_LO_RST 4'h6
`define MMCF_CFG1_RST 5'h10
`define MMCF_EOP_SYNC_RST 3'h7

// ***********************************
// Frame limits, collision limit and remote control type
// ***********************************
`define MMCF_MIN_FRAME 11'h03C
`define MMCF_MIN_RUNT 11'h006
`define MMCF_COL_LIMIT 5'h10
`define MMCF_REMOTE_TYPE 16'h0900

`endif

// ==== mmcf_top_assertions.sv ====
// Concurrent checks on the ports of the mode and filter block
`timescale 1ns/1ps
module mmcf_checker (
	input wire clk,
	input wire rst_n,
	input wire reg_rd,
	input wire reg_rvalid,
	input wire tx_frame_start,
	input wire tx_collision,
	input wire tx_clash_any,
	input wire tx_clash_limit,
	input wire tx_retry,
	input wire dma_want,
	input wire dma_request,
	input wire dma_end_seen,
	input wire power_down,
	input wire rx_valid,
	input wire rx_ready,
	input wire rx_last,
	input wire rx_frame_keep,
	input wire rx_frame_drop,
	input wire rx_remote_frame
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	// ****
	// Register bus and collision counter
	// ****
	AST_READ_ANSWER: assert property (reg_rd |=> reg_rvalid)
		else $error("read got no answer");
	AST_LIMIT_FLAGS: assert property (tx_clash_limit |-> tx_clash_any)
		else $error("limit without collision flag");
	AST_FIRST_HIT: assert property ((tx_collision && !tx_frame_start) ##1
		!tx_frame_start |=> tx_clash_any) else $error("collision not counted");
	AST_START_CLEARS: assert property (tx_frame_start ##1 !tx_collision
		|=> !tx_clash_any) else $error("count not cleared at start");
	AST_RETRY_CAUSE: assert property (tx_retry |-> $past(tx_collision)
		&& !$past(tx_clash_limit)) else $error("stray retry");
	AST_LIMIT_HOLD: assert property (tx_clash_limit && !tx_frame_start
		&& !$past(tx_frame_start) |=> tx_clash_limit) else $error("limit lost");
	AST_LAST_NO_RETRY: assert property ($rose(tx_clash_limit)
		|-> !$past(tx_retry)) else $error("retry on sixteenth collision");
	// ****
	// DMA request and receive verdicts
	// ****
	AST_DMA_WANT: assert property (!dma_want |=> !dma_request)
		else $error("request without demand");
	AST_DMA_END: assert property (dma_end_seen |=> !dma_request)
		else $error("request after end marker");
	AST_DMA_SLEEP: assert property (power_down ##1 power_down
		|-> !dma_request) else $error("request while asleep");
	AST_FRAME_CAUSE: assert property (rx_frame_keep || rx_frame_drop
		|-> $past(rx_valid && rx_ready && rx_last)) else $error("stray verdict");
	AST_REMOTE_KEPT: assert property (rx_remote_frame |-> rx_frame_keep)
		else $error("remote report on unkept frame");
endmodule
bind mmcf_top mmcf_checker mmcf_checker_inst (.clk, .rst_n, .reg_rd,
	.reg_rvalid, .tx_frame_start, .tx_collision, .tx_clash_any,
	.tx_clash_limit, .tx_retry, .dma_want, .dma_request, .dma_end_seen,
	.power_down, .rx_valid, .rx_ready, .rx_last, .rx_frame_keep,
	.rx_frame_drop, .rx_remote_frame);

// ==== mmcf_host_drain.sv ====
// Host reader model that drains the receive buffer
`timescale 1ns/1ps
module mmcf_host_drain (
	input wire clk,
	input wire hold,
	input wire slow,
	output logic buf_ready
);
	logic [2:0] tick_r = 3'h0;
	// Falling edge moves, so the block always samples a settled ready;
	// slow mode stalls two cycles in eight to back up the buffer
	always @(negedge clk) begin
		tick_r <= tick_r + 3'h1;
		buf_ready <= !hold && !(slow && tick_r[2:1] == 2'h3);
	end
endmodule

// ==== test_mmcf_top.sv ====
// Self-checking bench for the mode, configuration and filter block
`timescale 1ns/1ps
module test_mmcf_top;
	logic clk, rst_n, reg_wr, reg_rd, tx_frame_start, tx_collision, dma_want;
	logic dma_end_marker, dma_clear, rx_valid, rx_last, rx_crc_err, hold;
	logic rx_align_err, rx_collision, rx_self, rx_pkt_pending, slow;
	logic [3:0] reg_addr;
	logic [7:0] reg_wdata, rx_byte, reg_rdata, buf_byte;
	logic [15:0] dma_left;
	logic [1:0] tx_partition, sram_size, bank_select;
	logic reg_rvalid, tx_clash_any, tx_clash_limit, tx_retry, link_active;
	logic tx_ignore_carrier, loopback_en, dma_request, dma_end_seen, rx_ready;
	logic buf_valid, buf_last, buf_ready, rx_frame_keep, rx_frame_drop;
	logic rx_remote_frame, power_down, word_mode_pin, end_marker_polarity;
	logic byte_lane_order;
	logic [15:0] q_rd[$], q_buf[$], q_fr[$];
	logic [31:0] lfsr;
	int err_total, checked, cyc, retries;
	mmcf_top mmcf_top_inst (.clk, .rst_n, .reg_addr, .reg_wr, .reg_rd,
		.reg_wdata, .reg_rdata, .reg_rvalid, .tx_frame_start, .tx_collision,
		.tx_clash_any, .tx_clash_limit, .tx_retry, .tx_ignore_carrier,
		.loopback_en, .dma_want, .dma_left, .dma_end_marker, .dma_clear,
		.dma_request, .dma_end_seen, .rx_valid, .rx_byte, .rx_last,
		.rx_crc_err, .rx_align_err, .rx_collision, .rx_self, .rx_ready,
		.buf_valid, .buf_byte, .buf_last, .buf_ready, .rx_pkt_pending,
		.rx_frame_keep, .rx_frame_drop, .rx_remote_frame, .link_active,
		.power_down, .word_mode_pin, .tx_partition, .sram_size,
		.bank_select, .end_marker_polarity, .byte_lane_order);
	mmcf_host_drain mmcf_host_drain_inst (.clk, .hold, .slow, .buf_ready);
	// ****
	// Helpers
	// ****
	function automatic logic [31:0] step(input logic [31:0] s);
		step = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic logic [7:0] sta(input int i);
		sta = {i[3:0], 4'h2};
	endfunction
	task chk(input logic [15:0] g, input logic [15:0] e);
		checked++;
		if (g !== e) begin
			err_total++;
			$display("mismatch at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task wr(input logic [3:0] a, input logic [7:0] d);
		@(negedge clk);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge clk);
		reg_wr = 1'b0;
		@(negedge clk);
	endtask
	task rd(input logic [3:0] a, input logic [7:0] e);
		@(negedge clk);
		reg_addr = a;
		reg_rd = 1'b1;
		q_rd.push_back(e);
		@(negedge clk);
		reg_rd = 1'b0;
	endtask
	// Byte stays offered until the buffer has room for it
	task rx_send(input logic [7:0] b, input logic l);
		@(negedge clk);
		rx_valid = 1'b1;
		rx_byte = b;
		rx_last = l;
		while (rx_ready !== 1'b1) @(negedge clk);
		q_buf.push_back({7'h00, l, b});
	endtask
	// Kind 0 own address, 1 broadcast, 2 another station,
	// 3 group address that hits both group filters, 4 one that misses both
	task frame(input logic [7:0] m, input int k, input int n,
		input logic [4:0] f, input logic [1:0] e);
		logic [7:0] b;
		wr(4'h5, m);
		{rx_self, rx_collision, rx_align_err, rx_crc_err} = f[3:0];
		for (int i = 0; i < n; i++) begin
			lfsr = step(lfsr);
			b = i < 6 ? (k == 1 ? 8'hFF : sta(i)) : lfsr[7:0];
			if (i == 5 && k == 2) b = b ^ 8'h01;
			if (k > 2 && i < 6)
				b = i == 0 ? 8'h03 : i > 3 ? 8'h00 : (k == 4 && i == 2) ? 8'h23 : b;
			if (i == 12) b = f[4] ? 8'h09 : 8'h08;
			if (i == 13) b = 8'h00;
			if (i == n - 1) q_fr.push_back({14'h0000, e});
			rx_send(b, i == n - 1);
		end
		@(negedge clk);
		rx_valid = 1'b0;
	endtask
	task tally_and_finish;
		$display("checked %0d err_total %0d", checked, err_total);
		if (err_total == 0 && checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// ****
	// Clock, watchdog and result monitor
	// ****
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// A hang counts as a failure rather than running forever
	always @(posedge clk) begin
		cyc++;
		if (cyc == 30000) begin
			err_total++;
			tally_and_finish();
		end
	end
	// Each answer is matched with the oldest outstanding note
	always @(posedge clk) begin
		if (tx_retry === 1'b1)
			retries++;
		if (reg_rvalid === 1'b1)
			chk(reg_rdata,
				q_rd.size() ? q_rd.pop_front() : 16'hXXXX);
		if (buf_valid === 1'b1 && buf_ready === 1'b1)
			chk({buf_last, buf_byte},
				q_buf.size() ? q_buf.pop_front() : 16'hXXXX);
		if (rx_frame_keep === 1'b1 || rx_frame_drop === 1'b1)
			chk({rx_frame_keep, rx_remote_frame},
				q_fr.size() ? q_fr.pop_front() : 16'hXXXX);
	end
	// ****
	// Main sequence
	// ****
	initial begin
		{rst_n, reg_wr, reg_rd, tx_frame_start, tx_collision, dma_want} = '0;
		{dma_clear, rx_valid, rx_last, rx_crc_err, rx_align_err, hold} = '0;
		{rx_collision, rx_self, rx_pkt_pending, slow} = '0;
		{reg_addr, reg_wdata, rx_byte, dma_left} = '0;
		dma_end_marker = 1'b1;
		lfsr = 32'hEAD86C23;
		repeat (3) @(negedge clk);
		rst_n = 1'b1;
		repeat (3) @(negedge clk);
		rd(4'h4, 8'h06);
		rd(4'h5, 8'h42);
		rd(4'h6, 8'hB6);
		rd(4'h7, 8'hA0);
		rd(4'h0, 8'h00);
		chk({word_mode_pin, link_active, loopback_en, tx_partition,
			sram_size}, 7'h06);
		wr(4'h4, 8'hFF);
		rd(4'h4, 8'h07);
		chk({loopback_en, tx_ignore_carrier}, 2'b01);
		wr(4'h4, 8'h04);
		chk({loopback_en, tx_ignore_carrier}, 2'b10);
		wr(4'h4, 8'h06);
		for (int k = 0; k < 4; k++) begin
			wr(4'h6, {2'b00, k[0], 1'b1, k[1:0], k[1], 1'b0});
			chk({word_mode_pin, link_active, tx_partition, sram_size},
				{~k[0], 1'b1, k[1:0], k[1], 1'b0});
		end
		wr(4'h7, 8'hFF);
		rd(4'h7, 8'hAF);
		rd(4'h8, 8'h00);
		chk({bank_select, end_marker_polarity, byte_lane_order}, 4'hF);
		wr(4'h7, 8'h20);
		wr(4'h5, 8'h3F);
		rx_pkt_pending = 1'b1;
		rd(4'h5, 8'h3F);
		rx_pkt_pending = 1'b0;
		rd(4'h5, 8'h7F);
		wr(4'h6, 8'hB6);
		for (int i = 0; i < 6; i++) wr(4'h8 + i[3:0], sta(i));
		wr(4'h7, 8'h24);
		wr(4'h8, 8'h5A);
		rd(4'h8, 8'h5A);
		wr(4'h7, 8'h20);
		rd(4'h8, 8'h02);
		rd(4'hD, 8'h52);
		rd(4'hE, 8'h00);
		for (int n = 0; n < 17; n++) begin
			@(negedge clk);
			tx_frame_start = 1'b1;
			retries = 0;
			@(negedge clk);
			tx_frame_start = 1'b0;
			repeat (n + (n == 16)) begin
				tx_collision = 1'b1;
				@(negedge clk);
				tx_collision = 1'b0;
				@(negedge clk);
			end
			@(negedge clk);
			chk({tx_clash_any, tx_clash_limit}, {n != 0, n == 16});
			chk(16'(retries), n > 15 ? 15 : n);
			rd(4'h4, {n[3:0], 4'h6});
		end
		frame(8'h03, 0, 64, 5'h00, 2'b00);
		wr(4'h6, 8'h36);
		slow = 1'b1;
		frame(8'h03, 2, 64, 5'h00, 2'b10);
		frame(8'h00, 0, 64, 5'h00, 2'b00);
		frame(8'h01, 0, 64, 5'h00, 2'b10);
		frame(8'h01, 1, 64, 5'h00, 2'b10);
		frame(8'h01, 2, 64, 5'h00, 2'b00);
		frame(8'h02, 0, 60, 5'h00, 2'b10);
		frame(8'h02, 2, 64, 5'h00, 2'b00);
		frame(8'h01, 3, 64, 5'h00, 2'b10);
		frame(8'h02, 3, 64, 5'h00, 2'b10);
		frame(8'h01, 4, 64, 5'h00, 2'b00);
		frame(8'h02, 4, 64, 5'h00, 2'b00);
		frame(8'h03, 0, 59, 5'h00, 2'b00);
		frame(8'h0B, 0, 6, 5'h00, 2'b10);
		frame(8'h0B, 0, 5, 5'h00, 2'b00);
		frame(8'h0B, 0, 40, 5'h01, 2'b00);
		frame(8'h23, 0, 64, 5'h01, 2'b10);
		frame(8'h23, 0, 40, 5'h02, 2'b10);
		frame(8'h23, 0, 64, 5'h05, 2'b00);
		frame(8'h03, 0, 64, 5'h01, 2'b00);
		frame(8'h07, 0, 64, 5'h10, 2'b11);
		frame(8'h03, 0, 64, 5'h10, 2'b10);
		frame(8'h01, 1, 64, 5'h08, 2'b00);
		frame(8'h03, 1, 64, 5'h08, 2'b10);
		wr(4'h6, 8'hB6);
		wr(4'h7, 8'h00);
		chk(power_down, 1'b1);
		frame(8'h03, 0, 64, 5'h00, 2'b00);
		rd(4'h8, 8'h02);
		wr(4'h7, 8'h20);
		chk(power_down, 1'b0);
		wr(4'h6, 8'h36);
		// Start from an empty buffer so that eight bytes fill it exactly
		while (buf_valid === 1'b1) @(negedge clk);
		hold = 1'b1;
		for (int i = 0; i < 8; i++) rx_send(sta(i), 1'b0);
		@(negedge clk);
		rx_valid = 1'b0;
		chk(rx_ready, 1'b0);
		hold = 1'b0;
		q_fr.push_back(16'h0000);
		rx_send(8'h77, 1'b1);
		@(negedge clk);
		rx_valid = 1'b0;
		repeat (30) @(negedge clk);
		chk({buf_valid, 15'(q_buf.size())}, 16'h0000);
		dma_want = 1'b1;
		// Earlier polarity settings left the end marker latched
		dma_clear = 1'b1;
		@(negedge clk);
		dma_clear = 1'b0;
		for (int j = 0; j < 8; j++) begin
			lfsr = step(lfsr);
			dma_left = j < 6 ? 16'(j >> 1) : lfsr[15:0];
			wr(4'h4, {5'h00, j[0], 2'b10});
			chk(dma_request, dma_left > 1 || (dma_left == 1 && !j[0]));
		end
		dma_left = 16'h0040;
		dma_end_marker = 1'b0;
		repeat (6) @(negedge clk);
		chk({dma_end_seen, dma_request}, 2'b10);
		dma_end_marker = 1'b1;
		repeat (6) @(negedge clk);
		dma_clear = 1'b1;
		@(negedge clk);
		dma_clear = 1'b0;
		repeat (2) @(negedge clk);
		chk({dma_end_seen, dma_request}, 2'b01);
		wr(4'h7, 8'h22);
		repeat (6) @(negedge clk);
		chk(dma_end_seen, 1'b1);
		wr(4'h7, 8'h02);
		chk(power_down, 1'b1);
		rst_n = 1'b0;
		repeat (3) @(negedge clk);
		rst_n = 1'b1;
		repeat (3) @(negedge clk);
		chk(power_down, 1'b0);
		chk(dma_end_seen, 1'b0);
		rd(4'h7, 8'hA0);
		repeat (3) @(negedge clk);
		tally_and_finish();
	end
endmodule
